/* inc/sctl_defs.svh */
`ifndef SCTL_DEFS_SVH
`define SCTL_DEFS_SVH
// -----------------------------------------------------------------------
// Word layout and register select codes.
// -----------------------------------------------------------------------
`define SCTL_WORD_W        32
`define SCTL_SEL_LSB       0
`define SCTL_SEL_MSB       3
`define SCTL_SEL_R0        4'h0
`define SCTL_SEL_R4        4'h4
`define SCTL_SEL_R5        4'h5
`define SCTL_SEL_R6        4'h6
`define SCTL_SEL_R7        4'h7
`define SCTL_SEL_R8        4'h8
// -----------------------------------------------------------------------
// Register four fields.
// -----------------------------------------------------------------------
`define SCTL_R4_REFHALF    25
`define SCTL_R4_RCNT_MSB   24
`define SCTL_R4_RCNT_LSB   15
`define SCTL_R4_DBUF       14
`define SCTL_R4_CP_MSB     13
`define SCTL_R4_CP_LSB     10
`define SCTL_R4_PD         6
`define SCTL_R4_CP3S       5
`define SCTL_R4_CRST       4
// -----------------------------------------------------------------------
// Register five fields.
// -----------------------------------------------------------------------
`define SCTL_R5_BDLY_MSB   27
`define SCTL_R5_BDLY_LSB   26
`define SCTL_R5_PBLEED     25
`define SCTL_R5_ABP        23
`define SCTL_R5_SLIP       19
// -----------------------------------------------------------------------
// Register six fields.
// -----------------------------------------------------------------------
`define SCTL_R6_DIFF       30
`define SCTL_R6_RFDIV_MSB  23
`define SCTL_R6_RFDIV_LSB  21
`define SCTL_R6_BLD_MSB    20
`define SCTL_R6_BLD_LSB    13
`define SCTL_R6_BLDEN      12
`define SCTL_R6_MUTE       11
`define SCTL_R6_RFEN       6
`define SCTL_R6_PWR_MSB    5
`define SCTL_R6_PWR_LSB    4
// -----------------------------------------------------------------------
// Register seven and eight fields.
// -----------------------------------------------------------------------
`define SCTL_R7_LDCNT_MSB  9
`define SCTL_R7_LDCNT_LSB  8
`define SCTL_R7_LOL        7
`define SCTL_R7_LDWIN      4
`define SCTL_R8_DITH       28
`define SCTL_R8_PH_MSB     27
`define SCTL_R8_PH_LSB     4
// -----------------------------------------------------------------------
// Reset values and timing.
// -----------------------------------------------------------------------
`define SCTL_RST_WORD      32'h0000_0000
`define SCTL_ABP_NARROW_PS 1600
`define SCTL_LDWIN_FRAC_PS 5000
`define SCTL_LDWIN_INT_PS  2400
// Reference-free cycles after which loss-of-lock mode drops lock.
`define SCTL_LOL_IDLE      8'h40
`endif

/* inc/sctl_pkg.sv */
package sctl_pkg;
  // Programming word carried on the link.
  typedef logic [31:0] sctl_word_t;
  // Register select codes known to both ends.
  typedef enum logic [3:0] {
    SCTL_REG0 = 4'h0,
    SCTL_REG4 = 4'h4,
    SCTL_REG5 = 4'h5,
    SCTL_REG6 = 4'h6,
    SCTL_REG7 = 4'h7,
    SCTL_REG8 = 4'h8
  } sctl_sel_e;
endpackage : sctl_pkg

/* inc/sctl_link_if.sv */
`timescale 1ns/100ps
// -----------------------------------------------------------------------
// Programming link: one word strobe with data, one clock.
// -----------------------------------------------------------------------
interface sctl_link_if;
  logic        load;
  logic [31:0] word;
  modport host (output load, output word);
  modport dev  (input load, input word);
endinterface : sctl_link_if

/* hdl/sctl_rdiv.sv */
`timescale 1ns/100ps
`include "sctl_defs.svh"
// -----------------------------------------------------------------------
// Reference path: R counter followed by optional halving toggle.
// -----------------------------------------------------------------------
module sctl_rdiv #(
  parameter int RW = 10
) (
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  input  wire logic          ref_tick_in,
  input  wire logic          hold_in,
  input  wire logic [RW-1:0] ratio_in,
  input  wire logic          half_in,
  output logic               pd_tick_out
);
  logic [RW-1:0] cnt_q, cnt_d;
  logic          tgl_q, tgl_d;
  logic          pd_q, pd_d;
  logic          wrap;

  // Count reference ticks; a ratio of 0 behaves as 1.
  always_comb begin
    cnt_d = cnt_q;
    tgl_d = tgl_q;
    pd_d  = 1'b0;
    wrap  = ref_tick_in && (cnt_q + RW'(1) >= ratio_in);
    if (hold_in) begin
      cnt_d = '0;
      tgl_d = 1'b0;
    end else if (ref_tick_in) begin
      cnt_d = wrap ? '0 : cnt_q + RW'(1);
      if (wrap) begin
        tgl_d = ~tgl_q;
        pd_d  = half_in ? tgl_q : 1'b1;
      end
    end
  end

  // Register the counter state.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
      tgl_q <= 1'b0;
      pd_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tgl_q <= tgl_d;
      pd_q  <= pd_d;
    end
  end

  assign pd_tick_out = pd_q;
endmodule : sctl_rdiv

/* hdl/sctl_dev.sv */
`timescale 1ns/100ps
`include "sctl_defs.svh"
// -----------------------------------------------------------------------
// -----------------------------------------------------------------------
module sctl_dev
  import sctl_pkg::*;
#(
  parameter int RW = 10
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RSTN_IN,
  sctl_link_if.dev         link,
  input  wire logic        REF_TICK_IN,
  input  wire logic        IN_WINDOW_IN,
  output logic             PD_TICK_OUT,
  output logic [3:0]       CP_CURRENT_OUT,
  output logic             CP_TRISTATE_OUT,
  output logic             COUNTER_HOLD_OUT,
  output logic             PULSED_BLEED_OUT,
  output logic [1:0]       ABP_DELAY_OUT,
  output logic             ABP_NARROW_OUT,
  output logic             SLIP_EN_OUT,
  output logic             REF_DIFF_OUT,
  output logic [2:0]       RF_DIV_OUT,
  output logic [7:0]       BLEED_VAL_OUT,
  output logic             BLEED_EN_OUT,
  output logic             RF_OUT_EN_OUT,
  output logic [1:0]       RF_POWER_OUT,
  output logic             LOCK_WIN_NARROW_OUT,
  output logic             LOCKED_OUT,
  output logic             DITHER_EN_OUT,
  output logic [23:0]      PHASE_SEED_OUT,
  output logic             POWER_DOWN_OUT
);
  // -----------------------------------------------------------------------
  // Register storage.
  // -----------------------------------------------------------------------
  sctl_word_t  r4_q, r4_d, r5_q, r5_d, r6_q, r6_d, r7_q, r7_d, r8_q, r8_d;
  logic [2:0]  rfdiv_q, rfdiv_d;
  logic [3:0]  sel;
  logic        pd_bit, hold;
  logic [7:0]  idle_q, idle_d;
  logic [2:0]  lcnt_q, lcnt_d;
  logic        lock_q, lock_d;
  logic        pd_tick;
  logic        ld_in_q, ld_in_d;

  // Decode of a select code against a register number.
  function automatic logic hit(input logic [3:0] s, input logic [3:0] c);
    return s == c;
  endfunction : hit

  // Lock count threshold for the two-bit count field.
  function automatic logic [2:0] need(input logic [1:0] f);
    return 3'(f) + 3'h1;
  endfunction : need

  assign sel    = link.word[`SCTL_SEL_MSB:`SCTL_SEL_LSB];
  assign pd_bit = r4_q[`SCTL_R4_PD];
  assign hold   = pd_bit || r4_q[`SCTL_R4_CRST];

  // Word routing; registers load even during power-down.
  always_comb begin
    r4_d = r4_q;
    r5_d = r5_q;
    r6_d = r6_q;
    r7_d = r7_q;
    r8_d = r8_q;
    rfdiv_d = rfdiv_q;
    if (link.load) begin
      if (hit(sel, `SCTL_SEL_R4)) r4_d = link.word;
      if (hit(sel, `SCTL_SEL_R5)) r5_d = link.word;
      if (hit(sel, `SCTL_SEL_R6)) r6_d = link.word;
      if (hit(sel, `SCTL_SEL_R7)) r7_d = link.word;
      if (hit(sel, `SCTL_SEL_R8)) r8_d = link.word;
      if (hit(sel, `SCTL_SEL_R6) && !r4_d[`SCTL_R4_DBUF]) begin
        rfdiv_d = link.word[`SCTL_R6_RFDIV_MSB:`SCTL_R6_RFDIV_LSB];
      end
      if (hit(sel, `SCTL_SEL_R0)) begin
        rfdiv_d = r6_q[`SCTL_R6_RFDIV_MSB:`SCTL_R6_RFDIV_LSB];
      end
    end
  end

  // Register the bank; power-down never clears it.
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      r4_q    <= `SCTL_RST_WORD;
      r5_q    <= `SCTL_RST_WORD;
      r6_q    <= `SCTL_RST_WORD;
      r7_q    <= `SCTL_RST_WORD;
      r8_q    <= `SCTL_RST_WORD;
      rfdiv_q <= 3'h0;
    end else begin
      r4_q    <= r4_d;
      r5_q    <= r5_d;
      r6_q    <= r6_d;
      r7_q    <= r7_d;
      r8_q    <= r8_d;
      rfdiv_q <= rfdiv_d;
    end
  end

  // -----------------------------------------------------------------------
  // Reference path.
  // -----------------------------------------------------------------------
  sctl_rdiv #(.RW(RW)) u_rdiv (
    .clk_in      (SYS_CLK_IN),
    .rstn_in     (RSTN_IN),
    .ref_tick_in (REF_TICK_IN),
    .hold_in     (hold),
    .ratio_in    (r4_q[`SCTL_R4_RCNT_MSB:`SCTL_R4_RCNT_LSB]),
    .half_in     (r4_q[`SCTL_R4_REFHALF]),
    .pd_tick_out (pd_tick)
  );

  // Lock detector counts consecutive in-window phase detector cycles.
  // In loss-of-lock mode a reference that stays away too long drops lock,
  // since the plain detector would otherwise keep reporting a stale lock.
  always_comb begin
    lcnt_d  = lcnt_q;
    lock_d  = lock_q;
    ld_in_d = IN_WINDOW_IN;
    idle_d  = REF_TICK_IN ? 8'h00
            : (idle_q == `SCTL_LOL_IDLE) ? idle_q : idle_q + 8'h01;
    if (pd_bit) begin
      lcnt_d = 3'h0;
      lock_d = 1'b0;
    end else if (pd_tick) begin
      if (!ld_in_q) begin
        lcnt_d = 3'h0;
        lock_d = 1'b0;
      end else if (lcnt_q + 3'h1 >= need(r7_q[`SCTL_R7_LDCNT_MSB:
                                                `SCTL_R7_LDCNT_LSB])) begin
        lock_d = 1'b1;
      end else begin
        lcnt_d = lcnt_q + 3'h1;
      end
    end else if (r7_q[`SCTL_R7_LOL] && idle_q == `SCTL_LOL_IDLE) begin
      lcnt_d = 3'h0;
      lock_d = 1'b0;
    end
  end

  // Register the lock detector state.
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      lcnt_q  <= 3'h0;
      lock_q  <= 1'b0;
      idle_q  <= 8'h00;
      ld_in_q <= 1'b0;
    end else begin
      lcnt_q  <= lcnt_d;
      lock_q  <= lock_d;
      idle_q  <= idle_d;
      ld_in_q <= ld_in_d;
    end
  end

  // -----------------------------------------------------------------------
  // Registered outputs.
  // -----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PD_TICK_OUT         <= 1'b0;
      CP_CURRENT_OUT      <= 4'h0;
      CP_TRISTATE_OUT     <= 1'b0;
      COUNTER_HOLD_OUT    <= 1'b0;
      PULSED_BLEED_OUT    <= 1'b0;
      ABP_DELAY_OUT       <= 2'h0;
      ABP_NARROW_OUT      <= 1'b0;
      SLIP_EN_OUT         <= 1'b0;
      REF_DIFF_OUT        <= 1'b0;
      RF_DIV_OUT          <= 3'h0;
      BLEED_VAL_OUT       <= 8'h00;
      BLEED_EN_OUT        <= 1'b0;
      RF_OUT_EN_OUT       <= 1'b0;
      RF_POWER_OUT        <= 2'h0;
      LOCK_WIN_NARROW_OUT <= 1'b0;
      LOCKED_OUT          <= 1'b0;
      DITHER_EN_OUT       <= 1'b0;
      PHASE_SEED_OUT      <= 24'h000000;
      POWER_DOWN_OUT      <= 1'b0;
    end else begin
      PD_TICK_OUT      <= pd_tick;
      CP_CURRENT_OUT   <= r4_q[`SCTL_R4_CP_MSB:`SCTL_R4_CP_LSB];
      CP_TRISTATE_OUT  <= r4_q[`SCTL_R4_CP3S] || pd_bit;
      COUNTER_HOLD_OUT <= hold;
      PULSED_BLEED_OUT <= r5_q[`SCTL_R5_PBLEED];
      ABP_DELAY_OUT    <= r5_q[`SCTL_R5_BDLY_MSB:`SCTL_R5_BDLY_LSB];
      ABP_NARROW_OUT   <= r5_q[`SCTL_R5_ABP];
      SLIP_EN_OUT      <= r5_q[`SCTL_R5_SLIP];
      REF_DIFF_OUT     <= r6_q[`SCTL_R6_DIFF];
      RF_DIV_OUT       <= rfdiv_q;
      BLEED_VAL_OUT    <= r6_q[`SCTL_R6_BLD_MSB:`SCTL_R6_BLD_LSB];
      BLEED_EN_OUT     <= r6_q[`SCTL_R6_BLDEN];
      RF_OUT_EN_OUT    <= r6_q[`SCTL_R6_RFEN] && !pd_bit
                          && (!r6_q[`SCTL_R6_MUTE] || lock_q);
      RF_POWER_OUT     <= r6_q[`SCTL_R6_PWR_MSB:`SCTL_R6_PWR_LSB];
      LOCK_WIN_NARROW_OUT <= r7_q[`SCTL_R7_LDWIN];
      LOCKED_OUT       <= lock_q;
      DITHER_EN_OUT    <= r8_q[`SCTL_R8_DITH];
      PHASE_SEED_OUT   <= r8_q[`SCTL_R8_PH_MSB:`SCTL_R8_PH_LSB];
      POWER_DOWN_OUT   <= pd_bit;
    end
  end
endmodule : sctl_dev

/* hdl/sctl_host.sv */
`timescale 1ns/100ps
`include "sctl_defs.svh"
// -----------------------------------------------------------------------
// Host end: takes a register number and field word, sends one word.
// -----------------------------------------------------------------------
module sctl_host
  import sctl_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        REQ_IN,
  input  wire logic [3:0]  SEL_IN,
  input  wire logic [27:0] FIELDS_IN,
  output logic             BUSY_OUT,
  sctl_link_if.host        link
);
  logic        load_q, load_d;
  logic [31:0] word_q, word_d;

  // Build the word: fields above, select code in low nibble.
  always_comb begin
    load_d = 1'b0;
    word_d = word_q;
    if (REQ_IN) begin
      load_d = 1'b1;
      word_d = {FIELDS_IN, SEL_IN};
    end
  end

  // Register the strobe and word.
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      load_q <= 1'b0;
      word_q <= `SCTL_RST_WORD;
    end else begin
      load_q <= load_d;
      word_q <= word_d;
    end
  end

  assign link.load = load_q;
  assign link.word = word_q;
  assign BUSY_OUT  = load_q;
endmodule : sctl_host

/* bench/sctl_link_sva.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Link checks between host and device ends.
// ----------------------------------------------------------------
module sctl_link_sva (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        load_in,
  input  wire logic [31:0] word_in,
  input  wire logic [23:0] seed_in,
  input  wire logic [3:0]  cp_cur_in,
  input  wire logic        cp_ts_in,
  input  wire logic        hold_in,
  input  wire logic        rf_en_in,
  input  wire logic        pdn_in,
  input  wire logic        locked_in
);
  // The word stays put between strobes so the device never sees a torn word.
  word_hold_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    !load_in |-> $stable(word_in))
    else $error("link word moved without a strobe");
  // Any change of the word comes together with its strobe.
  word_strobe_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    $changed(word_in) |-> load_in)
    else $error("link word changed outside a strobe");
  // A register eight word reaches the phase seed output two edges on.
  seed_route_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    load_in && word_in[3:0] == 4'h8
    |-> ##2 seed_in == $past(word_in[27:4], 2))
    else $error("phase seed does not follow its word");
  // A register four word reaches the pump current output two edges on.
  cp_route_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    load_in && word_in[3:0] == 4'h4
    |-> ##2 cp_cur_in == $past(word_in[13:10], 2))
    else $error("pump current does not follow its word");
  // Power-down floats the pump, holds the counters and stops the output.
  pd_pump_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    pdn_in |-> cp_ts_in && hold_in && !rf_en_in)
    else $error("power-down left pump, counters or output active");
  // Power-down clears the lock indication one cycle later.
  pd_lock_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    pdn_in |=> !locked_in)
    else $error("lock indication kept during power-down");
  // Main traffic kinds seen on the link.
  cover property (@(posedge clk_in) load_in && word_in[3:0] == 4'h4);
  cover property (@(posedge clk_in) load_in && word_in[3:0] == 4'h8);
endmodule : sctl_link_sva

/* bench/tb.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Bench: host end drives device end across the link.
// ----------------------------------------------------------------
module tb import sctl_pkg::*;;
  logic        sys_clk, rst_n, req, ref_tick, in_win, busy, pd_tick;
  logic        cp_ts, hold, pbleed, abp_nar, slip, rdiff, bleed_en;
  logic        rf_en, ld_nar, locked, dith, pdn;
  logic [3:0]  sel, cp_cur;
  logic [27:0] fields;
  logic [1:0]  abp_dly, rf_pwr;
  logic [2:0]  rf_div;
  logic [7:0]  bleed_val;
  logic [23:0] seed;
  int          n_fail, samples_checked, ticks, tick_base;

  sctl_link_if sctl_link_if_i ();
  sctl_host sctl_host_i (.SYS_CLK_IN(sys_clk), .RSTN_IN(rst_n),
    .REQ_IN(req), .SEL_IN(sel), .FIELDS_IN(fields), .BUSY_OUT(busy),
    .link(sctl_link_if_i));
  sctl_dev #(.RW(10)) sctl_dev_i (.SYS_CLK_IN(sys_clk), .RSTN_IN(rst_n),
    .link(sctl_link_if_i), .REF_TICK_IN(ref_tick), .IN_WINDOW_IN(in_win),
    .PD_TICK_OUT(pd_tick), .CP_CURRENT_OUT(cp_cur), .CP_TRISTATE_OUT(cp_ts),
    .COUNTER_HOLD_OUT(hold), .PULSED_BLEED_OUT(pbleed),
    .ABP_DELAY_OUT(abp_dly), .ABP_NARROW_OUT(abp_nar), .SLIP_EN_OUT(slip),
    .REF_DIFF_OUT(rdiff), .RF_DIV_OUT(rf_div), .BLEED_VAL_OUT(bleed_val),
    .BLEED_EN_OUT(bleed_en), .RF_OUT_EN_OUT(rf_en), .RF_POWER_OUT(rf_pwr),
    .LOCK_WIN_NARROW_OUT(ld_nar), .LOCKED_OUT(locked),
    .DITHER_EN_OUT(dith), .PHASE_SEED_OUT(seed), .POWER_DOWN_OUT(pdn));
  sctl_link_sva sctl_link_sva_i (.clk_in(sys_clk), .rstn_in(rst_n),
    .load_in(sctl_link_if_i.load), .word_in(sctl_link_if_i.word),
    .seed_in(seed), .cp_cur_in(cp_cur), .cp_ts_in(cp_ts), .hold_in(hold),
    .rf_en_in(rf_en), .pdn_in(pdn), .locked_in(locked));

  // Free-running system clock.
  always #5 sys_clk = ~sys_clk;

  // Counts phase detector ticks for the divider checks.
  always @(posedge sys_clk) begin
    if (pd_tick === 1'b1) ticks <= ticks + 1;
  end

  // Compares one value and keeps the tallies.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Sends one whole word; outputs have settled when it returns.
  task automatic send(input logic [3:0] s, input logic [31:0] w);
    @(negedge sys_clk);
    req = 1'b1;
    sel = s;
    fields = w[31:4];
    @(negedge sys_clk);
    req = 1'b0;
    chk("busy", 32'h1, {31'h0, busy});
    repeat (3) @(negedge sys_clk);
  endtask : send

  // Gives n reference edges, one every two cycles.
  task automatic refs(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      ref_tick = 1'b1;
      @(negedge sys_clk);
      ref_tick = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
  endtask : refs

  // Checks the phase detector ticks seen since the last call; the divider
  // starts from zero after a hold, so the count is exact.
  task automatic near(input int e);
    chk("pd ticks", e, ticks - tick_base);
    tick_base = ticks;
  endtask : near

  // Prints the verdict and ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // Cuts a hang short.
  initial begin
    #100000;
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end

  // Main sequence of tests.
  initial begin
    {sys_clk, rst_n, req, ref_tick, in_win} = 5'h00;
    sel = 4'h0;
    fields = 28'h0;
    tick_base = 0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("seed", 32'h0, seed);
    chk("outs", 32'h0, {cp_cur, cp_ts, hold, pdn, rf_en, locked, rf_div});
    $display("test reset done");
    send(4'h4, 32'h0001_A834);
    chk("cp current", 32'hA, cp_cur);
    chk("cp tristate", 32'h1, cp_ts);
    chk("hold", 32'h1, hold);
    chk("power down", 32'h0, pdn);
    tick_base = ticks;
    refs(6);
    near(0);
    send(4'h4, 32'h0001_A804);
    refs(30);
    near(10);
    // Halving and minimum pump current, as slip reduction needs them.
    send(4'h4, 32'h0201_8004);
    chk("cp minimum", 32'h0, cp_cur);
    refs(30);
    near(5);
    $display("test reg four done");
    send(4'h5, 32'h0A88_0005);
    chk("pulsed bleed", 32'h1, pbleed);
    chk("abp delay", 32'h2, abp_dly);
    chk("abp narrow", 32'h1, abp_nar);
    chk("slip", 32'h1, slip);
    // Constant bleed enable bit written clear while pulsed bleed is on.
    send(4'h6, 32'h40B4_A876);
    chk("ref diff", 32'h1, rdiff);
    chk("rf div", 32'h5, rf_div);
    chk("bleed val", 32'hA5, bleed_val);
    chk("bleed off", 32'h0, bleed_en);
    chk("rf power", 32'h3, rf_pwr);
    chk("rf muted", 32'h0, rf_en);
    send(4'h5, 32'h0880_0005);
    chk("pulsed off", 32'h0, pbleed);
    chk("slip off", 32'h0, slip);
    $display("test reg five six done");
    send(4'h4, 32'h0000_A804);
    send(4'h7, 32'h0000_0197);
    chk("lock window", 32'h1, ld_nar);
    in_win = 1'b1;
    refs(1);
    chk("early lock", 32'h0, locked);
    refs(3);
    chk("locked", 32'h1, locked);
    chk("rf on", 32'h1, rf_en);
    // About 36 reference-free cycles: below the 64-cycle loss threshold.
    repeat (32) @(negedge sys_clk);
    chk("held lock", 32'h1, locked);
    // About 76 reference-free cycles: past the threshold and its latency.
    repeat (40) @(negedge sys_clk);
    chk("lost lock", 32'h0, locked);
    refs(2);
    chk("relocked", 32'h1, locked);
    $display("test lock done");
    send(4'h0, 32'h001F_FFF0);
    send(4'h4, 32'h0000_A844);
    chk("power down", 32'h1, pdn);
    chk("pd pump", 32'h1, cp_ts);
    chk("pd hold", 32'h1, hold);
    chk("pd lock", 32'h0, locked);
    chk("pd rf", 32'h0, rf_en);
    send(4'h8, 32'h1FFF_FFD8);
    chk("dither", 32'h1, dith);
    chk("seed", 32'hFF_FFFD, seed);
    send(4'h0, 32'h0000_0640);
    send(4'h4, 32'h0000_A804);
    chk("power up", 32'h0, pdn);
    chk("kept cp", 32'hA, cp_cur);
    chk("kept div", 32'h5, rf_div);
    $display("test power down done");
    send(4'hF, 32'hFFFF_FFFF);
    chk("bad code seed", 32'hFF_FFFD, seed);
    chk("bad code cp", 32'hA, cp_cur);
    send(4'h4, 32'h0000_E804);
    send(4'h6, 32'h4054_B876);
    chk("buffered div", 32'h5, rf_div);
    chk("bleed on", 32'h1, bleed_en);
    send(4'h0, 32'h0000_0640);
    chk("applied div", 32'h2, rf_div);
    $display("test buffer done");
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("seed 2", 32'h0, seed);
    chk("outs 2", 32'h0, {cp_cur, cp_ts, hold, pdn, rf_en, locked, rf_div});
    send(4'h8, 32'h1FFF_FFD8);
    chk("seed again", 32'hFF_FFFD, seed);
    $display("test second reset done");
    stop_test();
  end
endmodule : tb
